// ---- pkg/csb_pkg.sv ----
// Shared constants and types for the compare, skip and relative branch unit.
// Assumes an 8-bit core with a word-addressed 16-bit program counter.
package csb_pkg;

	// Datapath widths.
	localparam int PC_W   = 16;
	localparam int DATA_W = 8;
	localparam int OFS_W  = 7;
	localparam int SEL_W  = 3;

	// Bit positions inside the status register.
	localparam logic [2:0] FLAG_C = 3'h0;
	localparam logic [2:0] FLAG_Z = 3'h1;
	localparam logic [2:0] FLAG_N = 3'h2;
	localparam logic [2:0] FLAG_V = 3'h3;
	localparam logic [2:0] FLAG_S = 3'h4;
	localparam logic [2:0] FLAG_H = 3'h5;
	localparam logic [2:0] FLAG_T = 3'h6;
	localparam logic [2:0] FLAG_I = 3'h7;

	// Cycle counts of the instruction classes.
	localparam logic [1:0] CYC_PLAIN     = 2'h1;
	localparam logic [1:0] CYC_SKIP_ONE  = 2'h2;
	localparam logic [1:0] CYC_SKIP_TWO  = 2'h3;
	localparam logic [1:0] CYC_BR_TAKEN  = 2'h2;
	localparam logic [1:0] CNT_LAST      = 2'h1;

	// Program counter steps in words.
	localparam logic [15:0] PC_STEP_NEXT     = 16'h0001;
	localparam logic [15:0] PC_STEP_SKIP_ONE = 16'h0002;
	localparam logic [15:0] PC_STEP_SKIP_TWO = 16'h0003;

	// Reset values.
	localparam logic [15:0] RST_PC     = 16'h0000;
	localparam logic [7:0]  RST_STATUS = 8'h00;
	localparam logic [1:0]  RST_CNT    = 2'h0;

	// Operation codes presented on the op port.
	typedef enum logic [4:0] {
		OP_COMPARE_SKIP_EQUAL      = 5'h00,
		OP_COMPARE_REGS            = 5'h01,
		OP_COMPARE_REGS_WITH_CARRY = 5'h02,
		OP_COMPARE_IMMEDIATE       = 5'h03,
		OP_SKIP_IF_REG_BIT_CLEAR   = 5'h04,
		OP_SKIP_IF_REG_BIT_SET     = 5'h05,
		OP_SKIP_IF_IO_BIT_CLEAR    = 5'h06,
		OP_SKIP_IF_IO_BIT_SET      = 5'h07,
		OP_BRANCH_IF_FLAG_SET      = 5'h08,
		OP_BRANCH_IF_FLAG_CLEAR    = 5'h09,
		OP_BRANCH_IF_EQUAL         = 5'h0a,
		OP_BRANCH_IF_NOT_EQUAL     = 5'h0b,
		OP_BRANCH_IF_CARRY_SET     = 5'h0c,
		OP_BRANCH_IF_CARRY_CLEAR   = 5'h0d,
		OP_BRANCH_IF_SAME_OR_HIGHER = 5'h0e,
		OP_BRANCH_IF_LOWER         = 5'h0f,
		OP_BRANCH_IF_MINUS         = 5'h10,
		OP_BRANCH_IF_PLUS          = 5'h11,
		OP_BRANCH_IF_GREATER_EQUAL = 5'h12,
		OP_BRANCH_IF_LESS_THAN     = 5'h13,
		OP_BRANCH_IF_HALF_CARRY_SET = 5'h14,
		OP_BRANCH_IF_HALF_CARRY_CLEAR = 5'h15,
		OP_BRANCH_IF_T_SET         = 5'h16,
		OP_BRANCH_IF_T_CLEAR       = 5'h17,
		OP_BRANCH_IF_OVERFLOW_SET  = 5'h18
	} csb_op_type;

	// Sequencer states, one-hot.
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_HOLD = 2'b10
	} csb_state_type;

	// Whole state of the top module.
	typedef struct packed {
		csb_state_type state;
		logic [1:0]    cnt;
		logic          busy;
		logic          done;
		logic          status_we;
		logic          illegal;
		logic          taken;
		logic [15:0]   pc_out;
		logic [7:0]    status_out;
	} csb_unit_state_type;

endpackage

// ---- src/csb_cmp.sv ----
// Flag generator for the compare instructions: subtracts and drops the result.
// Assumes the caller only uses the flags when a compare is executing.
`timescale 1ns/1ps
module csb_cmp (
	input  wire logic [7:0] a_val,
	input  wire logic [7:0] b_val,
	input  wire logic       use_carry,
	input  wire logic [7:0] status_in,
	output logic [7:0]      status_out
);
	import csb_pkg::*;

	logic       cin;
	logic [8:0] diff;
	logic [7:0] r;

	// The difference is only needed for flag derivation; no result leaves.
	assign cin  = use_carry & status_in[FLAG_C];
	assign diff = {1'b0, a_val} - {1'b0, b_val} - {8'h00, cin};
	assign r    = diff[7:0];

	// Borrow style carry, half carry and overflow of a subtraction.
	always_comb begin
		status_out         = status_in;
		status_out[FLAG_C] = (~a_val[7] & b_val[7]) | (b_val[7] & r[7]) | (r[7] & ~a_val[7]); // [RULE_02]
		status_out[FLAG_H] = (~a_val[3] & b_val[3]) | (b_val[3] & r[3]) | (r[3] & ~a_val[3]); // [RULE_02]
		status_out[FLAG_V] = (a_val[7] & ~b_val[7] & ~r[7]) | (~a_val[7] & b_val[7] & r[7]); // [RULE_02]
		status_out[FLAG_N] = r[7]; // [RULE_02]
		// With carry the zero flag only clears, so chained compares test the whole word.
		if (use_carry) begin
			status_out[FLAG_Z] = (r == 8'h00) & status_in[FLAG_Z]; // [RULE_02]
		end else begin
			status_out[FLAG_Z] = (r == 8'h00); // [RULE_02]
		end
	end
endmodule

// ---- src/csb_cond.sv ----
// Condition decoder: classifies an operation and evaluates its test.
// Assumes operands are stable while the op is presented.
`timescale 1ns/1ps
module csb_cond (
	input  csb_pkg::csb_op_type op,
	input  wire logic [7:0]     status_in,
	input  wire logic [7:0]     rd_val,
	input  wire logic [7:0]     rr_val,
	input  wire logic [7:0]     io_val,
	input  wire logic [2:0]     bit_sel,
	input  wire logic [2:0]     flag_sel,
	output logic                is_compare,
	output logic                is_skip,
	output logic                is_branch,
	output logic                use_carry,
	output logic                use_imm,
	output logic                cond,
	output logic                legal
);
	import csb_pkg::*;

	logic sign_lt;

	// Sign-corrected less-than.
	assign sign_lt = status_in[FLAG_N] ^ status_in[FLAG_V]; // [RULE_10]

	// One test per operation; unlisted codes are flagged illegal.
	always_comb begin
		is_compare = 1'b0;
		is_skip    = 1'b0;
		is_branch  = 1'b0;
		use_carry  = 1'b0;
		use_imm    = 1'b0;
		cond       = 1'b0;
		legal      = 1'b1;
		unique case (op)
			OP_COMPARE_SKIP_EQUAL: begin
				is_skip = 1'b1;
				cond    = (rd_val == rr_val); // [RULE_01]
			end
			OP_COMPARE_REGS: begin
				is_compare = 1'b1;
			end
			OP_COMPARE_REGS_WITH_CARRY: begin
				is_compare = 1'b1;
				use_carry  = 1'b1;
			end
			OP_COMPARE_IMMEDIATE: begin
				is_compare = 1'b1;
				use_imm    = 1'b1;
			end
			OP_SKIP_IF_REG_BIT_CLEAR: begin
				is_skip = 1'b1;
				cond    = ~rr_val[bit_sel]; // [RULE_03]
			end
			OP_SKIP_IF_REG_BIT_SET: begin
				is_skip = 1'b1;
				cond    = rr_val[bit_sel]; // [RULE_03]
			end
			OP_SKIP_IF_IO_BIT_CLEAR: begin
				is_skip = 1'b1;
				cond    = ~io_val[bit_sel]; // [RULE_04]
			end
			OP_SKIP_IF_IO_BIT_SET: begin
				is_skip = 1'b1;
				cond    = io_val[bit_sel]; // [RULE_04]
			end
			OP_BRANCH_IF_FLAG_SET: begin
				is_branch = 1'b1;
				cond      = status_in[flag_sel]; // [RULE_05]
			end
			OP_BRANCH_IF_FLAG_CLEAR: begin
				is_branch = 1'b1;
				cond      = ~status_in[flag_sel]; // [RULE_05]
			end
			OP_BRANCH_IF_EQUAL: begin
				is_branch = 1'b1;
				cond      = status_in[FLAG_Z]; // [RULE_07]
			end
			OP_BRANCH_IF_NOT_EQUAL: begin
				is_branch = 1'b1;
				cond      = ~status_in[FLAG_Z]; // [RULE_07]
			end
			OP_BRANCH_IF_CARRY_SET, OP_BRANCH_IF_LOWER: begin
				is_branch = 1'b1;
				cond      = status_in[FLAG_C]; // [RULE_08]
			end
			OP_BRANCH_IF_CARRY_CLEAR, OP_BRANCH_IF_SAME_OR_HIGHER: begin
				is_branch = 1'b1;
				cond      = ~status_in[FLAG_C]; // [RULE_08]
			end
			OP_BRANCH_IF_MINUS: begin
				is_branch = 1'b1;
				cond      = status_in[FLAG_N]; // [RULE_09]
			end
			OP_BRANCH_IF_PLUS: begin
				is_branch = 1'b1;
				cond      = ~status_in[FLAG_N]; // [RULE_09]
			end
			OP_BRANCH_IF_GREATER_EQUAL: begin
				is_branch = 1'b1;
				cond      = ~sign_lt; // [RULE_10]
			end
			OP_BRANCH_IF_LESS_THAN: begin
				is_branch = 1'b1;
				cond      = sign_lt; // [RULE_10]
			end
			OP_BRANCH_IF_HALF_CARRY_SET: begin
				is_branch = 1'b1;
				cond      = status_in[FLAG_H]; // [RULE_11]
			end
			OP_BRANCH_IF_HALF_CARRY_CLEAR: begin
				is_branch = 1'b1;
				cond      = ~status_in[FLAG_H]; // [RULE_11]
			end
			OP_BRANCH_IF_T_SET: begin
				is_branch = 1'b1;
				cond      = status_in[FLAG_T]; // [RULE_12]
			end
			OP_BRANCH_IF_T_CLEAR: begin
				is_branch = 1'b1;
				cond      = ~status_in[FLAG_T]; // [RULE_12]
			end
			OP_BRANCH_IF_OVERFLOW_SET: begin
				is_branch = 1'b1;
				cond      = status_in[FLAG_V]; // [RULE_13]
			end
			default: begin
				legal = 1'b0;
			end
		endcase
	end
endmodule

// ---- src/csb_unit.sv ----
// Execution unit for compare, conditional skip and conditional relative branch.
// Assumes the core presents one operation per issue strobe, with the address
// of that instruction on pc_in and the live status register on status_in,
// and that it holds off new issues while busy is high.
//
// Notes on behaviour
// [RULE_01] Compare-skip-equal skips on match; 1/2/3 cycles.
// [RULE_02] Compares set Z,N,V,C,H; result discarded; 1 cycle.
// [RULE_03] Register bit skips test clear or set bit.
// [RULE_04] I/O bit skips test bit; flags untouched.
// [RULE_05] Flag branches test selected status bit.
// [RULE_06] Branches: 1 cycle untaken, 2 taken; flags kept.
// [RULE_07] Equal branches follow the zero flag.
// [RULE_08] Carry and lower/higher branches follow carry.
// [RULE_09] Minus and plus branches follow negative flag.
// [RULE_10] Signed branches use negative xor overflow.
// [RULE_11] Half-carry branches follow the half-carry flag.
// [RULE_12] T branches follow the transfer bit flag.
// [RULE_13] Overflow-set branch follows the overflow flag.
// [RULE_14] Branch offset is signed two's complement.
`timescale 1ns/1ps
module csb_unit (
	input  wire logic           mclk,
	input  wire logic           rst,
	input  wire logic           issue,
	input  csb_pkg::csb_op_type op,
	input  wire logic [15:0]    pc_in,
	input  wire logic [7:0]     status_in,
	input  wire logic [7:0]     rd_val,
	input  wire logic [7:0]     rr_val,
	input  wire logic [7:0]     imm_val,
	input  wire logic [7:0]     io_val,
	input  wire logic [2:0]     bit_sel,
	input  wire logic [2:0]     flag_sel,
	input  wire logic [6:0]     offset,
	input  wire logic           next_two_word,
	output logic                busy,
	output logic                done,
	output logic                taken,
	output logic [15:0]         pc_out,
	output logic [7:0]          status_out,
	output logic                status_we,
	output logic                illegal
);
	import csb_pkg::*;

	csb_unit_state_type s_ff;
	csb_unit_state_type nxt_s;

	logic        is_compare;
	logic        is_skip;
	logic        is_branch;
	logic        use_carry;
	logic        use_imm;
	logic        cond;
	logic        legal;
	logic [7:0]  cmp_b;
	logic [7:0]  cmp_status;
	logic [15:0] ofs_ext;
	logic [15:0] branch_target;
	logic [15:0] skip_target;
	logic [15:0] next_pc;
	logic [1:0]  skip_cycles;
	logic        accept;

	// Classification and condition test of the presented operation.
	csb_cond u_cond (
		.op         (op),
		.status_in  (status_in),
		.rd_val     (rd_val),
		.rr_val     (rr_val),
		.io_val     (io_val),
		.bit_sel    (bit_sel),
		.flag_sel   (flag_sel),
		.is_compare (is_compare),
		.is_skip    (is_skip),
		.is_branch  (is_branch),
		.use_carry  (use_carry),
		.use_imm    (use_imm),
		.cond       (cond),
		.legal      (legal)
	);

	// The immediate form compares against the constant, not the second register.
	assign cmp_b = use_imm ? imm_val : rr_val;

	// Subtraction whose only product is the new flag set.
	csb_cmp u_cmp (
		.a_val      (rd_val),
		.b_val      (cmp_b),
		.use_carry  (use_carry),
		.status_in  (status_in),
		.status_out (cmp_status)
	);

	// Sign extension lets a taken branch move backward as well as forward.
	assign ofs_ext = {{(PC_W - OFS_W){offset[OFS_W - 1]}}, offset}; // [RULE_14]

	// Relative target: own address plus offset plus one; wraps modulo 2^16.
	assign branch_target = pc_in + ofs_ext + PC_STEP_NEXT; // [RULE_05] [RULE_07] [RULE_09] [RULE_13]

	// A skip hops over one or two words depending on the size of the next instruction.
	assign skip_target = next_two_word ? (pc_in + PC_STEP_SKIP_TWO) : (pc_in + PC_STEP_SKIP_ONE); // [RULE_01]
	assign skip_cycles = next_two_word ? CYC_SKIP_TWO : CYC_SKIP_ONE; // [RULE_01] [RULE_03] [RULE_04]

	// New issues are only taken while idle; an issue during busy is dropped.
	assign accept = issue & (s_ff.state == ST_IDLE);

	// Next program counter for the accepted operation.
	always_comb begin
		next_pc = pc_in + PC_STEP_NEXT;
		if (legal && is_branch && cond) begin
			next_pc = branch_target; // [RULE_05] [RULE_07] [RULE_08] [RULE_10]
		end else if (legal && is_skip && cond) begin
			next_pc = skip_target; // [RULE_01] [RULE_03] [RULE_04]
		end
	end

	// Sequencer: latches results on issue and holds busy for the extra cycles.
	// Done pulses on the last cycle of the instruction, but pc_out, taken and the flags
	// are already registered on the cycle after issue and hold while busy is high.
	always_comb begin
		nxt_s           = s_ff;
		nxt_s.done      = 1'b0;
		nxt_s.status_we = 1'b0;
		unique case (s_ff.state)
			ST_IDLE: begin
				if (accept) begin
					nxt_s.pc_out  = next_pc;
					nxt_s.illegal = ~legal;
					nxt_s.taken   = legal & (is_branch | is_skip) & cond;
					// Only compares touch the flags; skips and branches pass them through.
					if (legal && is_compare) begin
						nxt_s.status_out = cmp_status; // [RULE_02]
					end else begin
						nxt_s.status_out = status_in; // [RULE_04] [RULE_06]
					end
					if (legal && is_skip && cond) begin
						nxt_s.state = ST_HOLD;
						nxt_s.busy  = 1'b1;
						nxt_s.cnt   = skip_cycles - CNT_LAST; // [RULE_01] [RULE_03] [RULE_04]
					end else if (legal && is_branch && cond) begin
						nxt_s.state = ST_HOLD;
						nxt_s.busy  = 1'b1;
						nxt_s.cnt   = CYC_BR_TAKEN - CNT_LAST; // [RULE_06] [RULE_11] [RULE_12] [RULE_13]
					end else begin
						// Single cycle: compares, untaken branches, untaken skips and illegal codes.
						nxt_s.done      = 1'b1; // [RULE_02] [RULE_06]
						nxt_s.status_we = legal & is_compare; // [RULE_02]
						nxt_s.cnt       = RST_CNT;
					end
				end
			end
			ST_HOLD: begin
				if (s_ff.cnt == CNT_LAST) begin
					nxt_s.state = ST_IDLE;
					nxt_s.busy  = 1'b0;
					nxt_s.done  = 1'b1;
					nxt_s.cnt   = RST_CNT;
				end else begin
					nxt_s.cnt = s_ff.cnt - CNT_LAST;
				end
			end
			default: begin
				// A corrupted state code recovers to idle without a result.
				nxt_s.state = ST_IDLE;
				nxt_s.busy  = 1'b0;
				nxt_s.cnt   = RST_CNT;
			end
		endcase
	end

	// State register with synchronous reset.
	always_ff @(posedge mclk) begin
		if (rst) begin
			s_ff.state      <= ST_IDLE;
			s_ff.cnt        <= RST_CNT;
			s_ff.busy       <= 1'b0;
			s_ff.done       <= 1'b0;
			s_ff.status_we  <= 1'b0;
			s_ff.illegal    <= 1'b0;
			s_ff.taken      <= 1'b0;
			s_ff.pc_out     <= RST_PC;
			s_ff.status_out <= RST_STATUS;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Outputs come straight from the state register.
	assign busy       = s_ff.busy;
	assign done       = s_ff.done;
	assign taken      = s_ff.taken;
	assign pc_out     = s_ff.pc_out;
	assign status_out = s_ff.status_out;
	assign status_we  = s_ff.status_we;
	assign illegal    = s_ff.illegal;
endmodule

// ---- verif/csb_unit_asserts.sv ----
// Port-level checker for the compare, skip and relative branch unit.
// Assumes it is bound to csb_unit; an issue while busy is ignored by the unit.
`timescale 1ns/1ps
module csb_unit_asserts (
	input wire logic           mclk,
	input wire logic           rst,
	input wire logic           issue,
	input csb_pkg::csb_op_type op,
	input wire logic [15:0]    pc_in,
	input wire logic [7:0]     status_in,
	input wire logic [7:0]     rd_val,
	input wire logic [7:0]     rr_val,
	input wire logic [7:0]     io_val,
	input wire logic [2:0]     bit_sel,
	input wire logic [6:0]     offset,
	input wire logic           next_two_word,
	input wire logic           busy,
	input wire logic           done,
	input wire logic           taken,
	input wire logic [15:0]    pc_out,
	input wire logic [7:0]     status_out,
	input wire logic           status_we
);
	import csb_pkg::*;
	logic acc;
	logic is_cmp;
	logic is_br;
	logic is_skip;
	// An issue only counts while idle; classes are decoded once here.
	assign acc     = issue & ~busy;
	assign is_cmp  = op inside {OP_COMPARE_REGS, OP_COMPARE_REGS_WITH_CARRY, OP_COMPARE_IMMEDIATE};
	assign is_br   = op inside {[OP_BRANCH_IF_FLAG_SET:OP_BRANCH_IF_OVERFLOW_SET]};
	assign is_skip = op inside {[OP_COMPARE_SKIP_EQUAL:OP_SKIP_IF_IO_BIT_SET]} & ~is_cmp;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	property p_cmp_one;
		acc && is_cmp |=> done && status_we && !taken && pc_out == $past(pc_in) + 16'h0001;
	endproperty
	a_cmp_one: assert property (p_cmp_one) else $error("compare did not finish in one cycle");
	property p_cmp_keep;
		acc && is_cmp |=> status_out[7:6] == $past(status_in[7:6]) && status_out[4] == $past(status_in[4]);
	endproperty
	a_cmp_keep: assert property (p_cmp_keep) else $error("compare touched an unrelated flag");
	property p_br_target;
		acc && is_br |=> taken ? pc_out == $past(pc_in) + {{9{$past(offset[6])}}, $past(offset)} + 16'h0001
			: pc_out == $past(pc_in) + 16'h0001;
	endproperty
	a_br_target: assert property (p_br_target) else $error("branch target wrong");
	property p_br_cycles;
		acc && is_br |=> if (taken) (busy && !done ##1 done && !busy) else (done && !busy);
	endproperty
	a_br_cycles: assert property (p_br_cycles) else $error("branch cycle count wrong");
	property p_br_flags;
		acc && is_br |=> !status_we && status_out == $past(status_in);
	endproperty
	a_br_flags: assert property (p_br_flags) else $error("branch altered the flags");
	property p_branch_if_equal;
		acc && op == OP_BRANCH_IF_EQUAL |=> taken == $past(status_in[1]);
	endproperty
	a_branch_if_equal: assert property (p_branch_if_equal) else $error("equal branch ignores zero flag");
	property p_branch_if_less_than;
		acc && op == OP_BRANCH_IF_LESS_THAN |=> taken == ($past(status_in[2]) ^ $past(status_in[3]));
	endproperty
	a_branch_if_less_than: assert property (p_branch_if_less_than) else $error("less-than branch condition wrong");
	property p_brvs;
		acc && op == OP_BRANCH_IF_OVERFLOW_SET |=> taken == $past(status_in[3]);
	endproperty
	a_brvs: assert property (p_brvs) else $error("overflow branch condition wrong");
	property p_cse;
		acc && op == OP_COMPARE_SKIP_EQUAL |=> taken == ($past(rd_val) == $past(rr_val));
	endproperty
	a_cse: assert property (p_cse) else $error("skip on equal condition wrong");
	property p_io_set;
		acc && op == OP_SKIP_IF_IO_BIT_SET |=> taken == $past(io_val[bit_sel]) && !status_we;
	endproperty
	a_io_set: assert property (p_io_set) else $error("io bit skip condition wrong");
	property p_skip_two;
		acc && is_skip && next_two_word ##1 taken |-> pc_out == $past(pc_in) + 16'h0003 && busy ##1 busy
			##1 done && !busy;
	endproperty
	a_skip_two: assert property (p_skip_two) else $error("two-word skip timing wrong");
endmodule

// ---- verif/csb_unit_tb.sv ----
// Self-checking bench for csb_unit: a reference model notes each expected
// result in a queue and a monitor compares it when done pulses.
`timescale 1ns/1ps
module csb_unit_tb;
	import csb_pkg::*;
	typedef struct packed {
		logic [15:0] pc;
		logic        tk;
		logic [7:0]  st;
		logic        we;
		logic        ill;
		logic [1:0]  cyc;
		logic [31:0] at;
	} csb_note_type;
	logic         mclk = 1'b0;
	logic         rst = 1'b1;
	logic         issue = 1'b0;
	csb_op_type   op = OP_COMPARE_REGS;
	logic [15:0]  pc_in = 16'h0000;
	logic [7:0]   status_in = 8'h00, rd_val = 8'h00, rr_val = 8'h00, imm_val = 8'h00, io_val = 8'h00;
	logic [2:0]   bit_sel = 3'h0, flag_sel = 3'h0;
	logic [6:0]   offset = 7'h00;
	logic         next_two_word = 1'b0;
	logic         busy, done, taken, status_we, illegal;
	logic [15:0]  pc_out;
	logic [7:0]   status_out;
	logic [31:0]  seed = 32'h0000004e, cyc = 32'h0;
	int           n_fail = 0, comparisons = 0;
	csb_note_type notes[$];

	csb_unit DUT (.mclk(mclk), .rst(rst), .issue(issue), .op(op), .pc_in(pc_in), .status_in(status_in),
		.rd_val(rd_val), .rr_val(rr_val), .imm_val(imm_val), .io_val(io_val), .bit_sel(bit_sel),
		.flag_sel(flag_sel), .offset(offset), .next_two_word(next_two_word), .busy(busy), .done(done),
		.taken(taken), .pc_out(pc_out), .status_out(status_out), .status_we(status_we), .illegal(illegal));

	// Clock and an edge counter used to time each operation.
	always #25 mclk = ~mclk;
	always @(posedge mclk) cyc <= cyc + 32'h1;

	function automatic logic [31:0] xs_next();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Reference model built from the instruction behaviour, read from the live inputs.
	function automatic csb_note_type predict();
		csb_note_type e;
		logic [8:0]   d;
		logic [4:0]   h;
		logic [7:0]   b, s;
		logic         ci, c;
		s = status_in;
		e = '0;
		e.pc = pc_in + 16'h0001;
		e.st = s;
		e.cyc = 2'h1;
		b = (op == OP_COMPARE_IMMEDIATE) ? imm_val : rr_val;
		ci = (op == OP_COMPARE_REGS_WITH_CARRY) & s[FLAG_C];
		case (op)
			OP_COMPARE_SKIP_EQUAL: c = (rd_val == rr_val);
			OP_SKIP_IF_REG_BIT_CLEAR: c = ~rr_val[bit_sel];
			OP_SKIP_IF_REG_BIT_SET: c = rr_val[bit_sel];
			OP_SKIP_IF_IO_BIT_CLEAR: c = ~io_val[bit_sel];
			OP_SKIP_IF_IO_BIT_SET: c = io_val[bit_sel];
			OP_BRANCH_IF_FLAG_SET: c = s[flag_sel];
			OP_BRANCH_IF_FLAG_CLEAR: c = ~s[flag_sel];
			OP_BRANCH_IF_EQUAL: c = s[FLAG_Z];
			OP_BRANCH_IF_NOT_EQUAL: c = ~s[FLAG_Z];
			OP_BRANCH_IF_CARRY_SET, OP_BRANCH_IF_LOWER: c = s[FLAG_C];
			OP_BRANCH_IF_CARRY_CLEAR, OP_BRANCH_IF_SAME_OR_HIGHER: c = ~s[FLAG_C];
			OP_BRANCH_IF_MINUS: c = s[FLAG_N];
			OP_BRANCH_IF_PLUS: c = ~s[FLAG_N];
			OP_BRANCH_IF_GREATER_EQUAL: c = ~(s[FLAG_N] ^ s[FLAG_V]);
			OP_BRANCH_IF_LESS_THAN: c = s[FLAG_N] ^ s[FLAG_V];
			OP_BRANCH_IF_HALF_CARRY_SET: c = s[FLAG_H];
			OP_BRANCH_IF_HALF_CARRY_CLEAR: c = ~s[FLAG_H];
			OP_BRANCH_IF_T_SET: c = s[FLAG_T];
			OP_BRANCH_IF_T_CLEAR: c = ~s[FLAG_T];
			OP_BRANCH_IF_OVERFLOW_SET: c = s[FLAG_V];
			default: c = 1'b0;
		endcase
		if (op inside {OP_COMPARE_REGS, OP_COMPARE_REGS_WITH_CARRY, OP_COMPARE_IMMEDIATE}) begin
			d = {1'b0, rd_val} - {1'b0, b} - {8'h00, ci};
			h = {1'b0, rd_val[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
			e.st[FLAG_C] = d[8];
			e.st[FLAG_H] = h[4];
			e.st[FLAG_N] = d[7];
			e.st[FLAG_V] = (rd_val[7] & ~b[7] & ~d[7]) | (~rd_val[7] & b[7] & d[7]);
			e.st[FLAG_Z] = (d[7:0] == 8'h00) & ((op != OP_COMPARE_REGS_WITH_CARRY) | s[FLAG_Z]);
			e.we = 1'b1;
		end else if (op > OP_BRANCH_IF_OVERFLOW_SET) begin
			e.ill = 1'b1;
		end else if (c && op >= OP_BRANCH_IF_FLAG_SET) begin
			e.tk = 1'b1;
			e.pc = pc_in + {{9{offset[6]}}, offset} + 16'h0001;
			e.cyc = 2'h2;
		end else if (c) begin
			e.tk = 1'b1;
			e.pc = pc_in + (next_two_word ? 16'h0003 : 16'h0002);
			e.cyc = next_two_word ? 2'h3 : 2'h2;
		end
		return e;
	endfunction

	// Issues one operation with random operands; refused issues are sprinkled in while busy.
	task automatic run_one(input logic [4:0] code);
		csb_note_type e;
		logic [31:0]  r, t, u;
		int           k;
		r = xs_next();
		t = xs_next();
		u = xs_next();
		op = csb_op_type'(code);
		{pc_in, status_in, rd_val} = r;
		{imm_val, io_val, offset, next_two_word, bit_sel, flag_sel} = t[29:0];
		rr_val = (t[31] || code == 5'h04 || code == 5'h05) ? rd_val : u[7:0];
		issue = 1'b1;
		e = predict();
		// Edge count before the sampling edge, so a one-cycle op shows done one count later.
		e.at = cyc;
		notes.push_back(e);
		for (k = 0; k < 4; k++) begin
			@(negedge mclk);
			if (done === 1'b1)
				break;
			issue = u[8 + k];
			pc_in = u[31:16];
		end
		if (k == 4) begin
			check(32'h1, 32'h0, "no done");
			give_verdict();
		end
	endtask

	// Takes the oldest note whenever done pulses and compares every result port.
	always @(negedge mclk) begin
		csb_note_type e;
		if (!rst && done === 1'b1) begin
			if (notes.size() == 0) begin
				check(32'h1, 32'h0, "unexpected done");
			end else begin
				e = notes.pop_front();
				check(pc_out, e.pc, "pc");
				check(taken, e.tk, "taken");
				check(status_out, e.st, "status");
				check(status_we, e.we, "write");
				check(illegal, e.ill, "illegal");
				check(cyc - e.at, e.cyc, "cycles");
				check(busy, 1'b0, "busy");
			end
		end
	end

	// Main sequence: reset, every code, random stream, reset again, more traffic.
	initial begin
		repeat (5) @(negedge mclk);
		rst = 1'b0;
		@(negedge mclk);
		check({busy, done, taken, status_we, illegal, status_out, pc_out}, 32'h0, "reset");
		$display("test reset done");
		for (int i = 0; i < 32; i++)
			run_one(5'(i));
		$display("test all codes done");
		repeat (600)
			run_one(5'(xs_next() % 32'h1a));
		$display("test random stream done");
		issue = 1'b0;
		// Let the monitor take the last result before reset hides it behind rst.
		@(negedge mclk);
		rst = 1'b1;
		repeat (2) @(negedge mclk);
		rst = 1'b0;
		@(negedge mclk);
		check({busy, done, taken, status_we, illegal, status_out, pc_out}, 32'h0, "second reset");
		repeat (100)
			run_one(5'(xs_next() % 32'h19));
		issue = 1'b0;
		repeat (3) @(negedge mclk);
		check(notes.size(), 32'h0, "pending notes");
		$display("test second reset done");
		give_verdict();
	end
endmodule

bind csb_unit csb_unit_asserts u_asserts (.mclk(mclk), .rst(rst), .issue(issue), .op(op), .pc_in(pc_in),
	.status_in(status_in), .rd_val(rd_val), .rr_val(rr_val), .io_val(io_val), .bit_sel(bit_sel),
	.offset(offset), .next_two_word(next_two_word), .busy(busy), .done(done), .taken(taken),
	.pc_out(pc_out), .status_out(status_out), .status_we(status_we));
